// >>> design/bsl_regs.sv
// Backlight brightness, setup and latched error-flag registers with dimming output
`timescale 1ns/100ps
module bsl_regs #(
	parameter int CH          = 6,
	parameter int TRIP_CYCLES = bsl_pkg::TRIP_CYCLES
) (
	// Clock and reset
	input  wire logic          mclk_in,
	input  wire logic          sys_rst_in,
	// Register port
	input  wire logic [7:0]    reg_addr_in,
	input  wire logic          reg_wr_in,
	input  wire logic [7:0]    reg_wdata_in,
	input  wire logic          reg_rd_in,
	output logic      [7:0]    reg_rdata_out,
	// Device pins
	input  wire logic          chip_en_in,
	input  wire logic          dim_pin_in,
	output logic               fault_pin_out,
	output logic               fault_pin_oe_out,
	// Analog monitor indications
	input  wire logic [CH-1:0] led_open_in,
	input  wire logic [CH-1:0] led_short_in,
	input  wire logic          boost_low_in,
	input  wire logic          overheat_in,
	input  wire logic          temp_ok_in,
	input  wire logic          low_supply_in,
	// Power stage control
	output logic               boost_enable_out,
	output logic               led_enable_out,
	output logic               pwm_out,
	output logic      [7:0]    dim_duty_out
);
	localparam int SW = 2 * CH + 6;
	localparam int CW = $clog2(TRIP_CYCLES + 1);

	logic [SW-1:0]   sync_s;
	logic [CH-1:0]   open_s;
	logic [CH-1:0]   short_s;
	logic            en_s;
	logic            dim_s;
	logic            blow_s;
	logic            heat_s;
	logic            tok_s;
	logic            supply_s;

	logic [7:0]      dimming_level_reg;
	logic [7:0]      setup_reg;
	logic [7:0]      error_flags_reg;
	logic [7:0]      error_flags_next;
	logic [7:0]      flag_set;
	logic            flag_clr;
	logic [CW-1:0]   low_cnt_reg;
	logic            overcurrent_error;
	logic            boost_off_reg;
	logic            heat_hold_reg;
	logic [7:0]      pwm_cnt_reg;
	logic [7:0]      meas_acc_reg;
	logic [7:0]      meas_duty_reg;
	logic [7:0]      duty_sel;
	logic [1:0]      dimming_source_select;
	logic            light_output_enable;
	logic            any_led_error;
	logic [CH-1:0]   ch_err;
	logic [3:0]      ch_count;
	logic            power_ok;

	function automatic logic [3:0] count_ones(input logic [CH-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < CH; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	function automatic logic is_access(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	bsl_sync #(
		.W (SW)
	) u_sync (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({led_open_in, led_short_in, chip_en_in, dim_pin_in, boost_low_in,
		              overheat_in, temp_ok_in, low_supply_in}),
		.sync_out   (sync_s)
	);

	assign {open_s, short_s, en_s, dim_s, blow_s, heat_s, tok_s, supply_s} = sync_s;

	assign dimming_source_select = setup_reg[bsl_pkg::SETUP_MODE_MSB:bsl_pkg::SETUP_MODE_LSB];
	assign light_output_enable   = setup_reg[bsl_pkg::SETUP_EN_BIT];
	assign ch_err                = open_s | short_s;
	assign ch_count              = count_ones(ch_err);
	assign any_led_error         = |ch_err;

	// Register writes
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			dimming_level_reg <= bsl_pkg::RST_LEVEL;
			setup_reg         <= bsl_pkg::RST_SETUP;
		end else if (reg_wr_in) begin
			if (is_access(reg_addr_in, bsl_pkg::OFF_LEVEL)) begin
				dimming_level_reg <= reg_wdata_in;
			end
			if (is_access(reg_addr_in, bsl_pkg::OFF_SETUP)) begin
				setup_reg <= reg_wdata_in & bsl_pkg::SETUP_USED_MASK;
			end
		end
	end

	// Flag events; set wins over clear
	always_comb begin
		flag_set = 8'h00;
		flag_set[bsl_pkg::FLAG_OPEN]   = |open_s;
		flag_set[bsl_pkg::FLAG_SHORT]  = |short_s;
		flag_set[bsl_pkg::FLAG_MULTI]  = ch_count >= 4'h2;
		flag_set[bsl_pkg::FLAG_ONE]    = ch_count == 4'h1;
		flag_set[bsl_pkg::FLAG_ANY]    = any_led_error;
		flag_set[bsl_pkg::FLAG_TRIP]   = overcurrent_error;
		flag_set[bsl_pkg::FLAG_HEAT]   = heat_s;
		flag_set[bsl_pkg::FLAG_SUPPLY] = supply_s;
	end

	assign flag_clr = (reg_rd_in && is_access(reg_addr_in, bsl_pkg::OFF_FLAGS)) || !en_s;
	assign error_flags_next = (flag_clr ? 8'h00 : error_flags_reg) | flag_set;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			error_flags_reg <= bsl_pkg::RST_FLAGS;
		end else begin
			error_flags_reg <= error_flags_next;
		end
	end

	// Open-drain fault pin pulled low while any flag stands
	assign fault_pin_out    = 1'b0;
	assign fault_pin_oe_out = |error_flags_reg;

	// Read data
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				bsl_pkg::OFF_LEVEL: reg_rdata_out <= dimming_level_reg;
				bsl_pkg::OFF_SETUP: reg_rdata_out <= setup_reg;
				bsl_pkg::OFF_FLAGS: reg_rdata_out <= error_flags_reg;
				default:            reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// Boost-low timer and restart after the flag is cleared
	assign overcurrent_error = blow_s && !boost_off_reg
		&& (low_cnt_reg == CW'(TRIP_CYCLES));

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			low_cnt_reg   <= '0;
			boost_off_reg <= 1'b0;
		end else begin
			if (!blow_s || boost_off_reg) begin
				low_cnt_reg <= '0;
			end else if (low_cnt_reg != CW'(TRIP_CYCLES)) begin
				low_cnt_reg <= low_cnt_reg + CW'(1);
			end
			if (overcurrent_error) begin
				boost_off_reg <= 1'b1;
			end else if (!error_flags_reg[bsl_pkg::FLAG_TRIP]) begin
				boost_off_reg <= 1'b0;
			end
		end
	end

	// Thermal hold until recovery indication
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			heat_hold_reg <= 1'b0;
		end else if (heat_s) begin
			heat_hold_reg <= 1'b1;
		end else if (tok_s) begin
			heat_hold_reg <= 1'b0;
		end
	end

	assign power_ok = light_output_enable && en_s && !heat_hold_reg && !supply_s;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			boost_enable_out <= 1'b0;
			led_enable_out   <= 1'b0;
		end else begin
			boost_enable_out <= power_ok && !boost_off_reg;
			led_enable_out   <= power_ok;
		end
	end

	// Input duty measured over each PWM period
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pwm_cnt_reg   <= 8'h00;
			meas_acc_reg  <= 8'h00;
			meas_duty_reg <= 8'h00;
		end else begin
			pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
			if (pwm_cnt_reg == bsl_pkg::PWM_WRAP) begin
				meas_duty_reg <= meas_acc_reg;
				meas_acc_reg  <= 8'h00;
			end else if (dim_s) begin
				meas_acc_reg <= meas_acc_reg + 8'h01;
			end
		end
	end

	always_comb begin
		unique case (dimming_source_select)
			bsl_pkg::SRC_REGISTER: duty_sel = dimming_level_reg;
			default:               duty_sel = meas_duty_reg;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			dim_duty_out <= 8'h00;
			pwm_out      <= 1'b0;
		end else begin
			dim_duty_out <= duty_sel;
			if (dimming_source_select == bsl_pkg::SRC_PASS) begin
				pwm_out <= dim_s && power_ok;
			end else begin
				pwm_out <= (pwm_cnt_reg < duty_sel) && power_ok;
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	sequence seq_flag_read;
		reg_rd_in && reg_addr_in == bsl_pkg::OFF_FLAGS && flag_set == 8'h00;
	endsequence
	sequence seq_flags_gone;
		error_flags_reg == 8'h00 && !fault_pin_oe_out;
	endsequence
	sequence seq_level_write;
		reg_wr_in && reg_addr_in == bsl_pkg::OFF_LEVEL;
	endsequence

	AST_LEVEL_WRITE: assert property (seq_level_write |=> dimming_level_reg == $past(reg_wdata_in))
		else $error("brightness write not stored");
	AST_REG_SOURCE: assert property (dimming_source_select == bsl_pkg::SRC_REGISTER
		|=> dim_duty_out == $past(dimming_level_reg))
		else $error("register source not applied");
	AST_RESET_ZERO: assert property (@(posedge mclk_in) disable iff (1'b0) sys_rst_in
		|=> dimming_level_reg == 8'h00 && setup_reg == 8'h00 && error_flags_reg == 8'h00)
		else $error("registers not zero after reset");
	AST_OPEN_LATCH: assert property (|open_s |=> error_flags_reg[bsl_pkg::FLAG_OPEN]
		&& fault_pin_oe_out)
		else $error("open fault not latched");
	AST_SHORT_LATCH: assert property (|short_s |=> error_flags_reg[bsl_pkg::FLAG_SHORT]
		&& fault_pin_oe_out)
		else $error("short fault not latched");
	AST_READ_CLEAR: assert property (seq_flag_read |=> seq_flags_gone)
		else $error("flag read did not clear");
	AST_UPPER_ZERO: assert property (reg_rd_in && reg_addr_in == bsl_pkg::OFF_SETUP
		|=> reg_rdata_out[7:3] == 5'h00)
		else $error("unused setup bits not zero");
	AST_MULTI_CH: assert property (ch_count >= 4'h2 |=> error_flags_reg[bsl_pkg::FLAG_MULTI]
		&& error_flags_reg[bsl_pkg::FLAG_ANY])
		else $error("multi-channel flag missing");
	AST_BOOST_TRIP: assert property (overcurrent_error |=> error_flags_reg[bsl_pkg::FLAG_TRIP]
		##1 !boost_enable_out)
		else $error("boost not stopped on trip");
	AST_HEAT_OFF: assert property (heat_s |=> ##1 !led_enable_out && !boost_enable_out)
		else $error("outputs on during overheat");
	AST_SUPPLY_OFF: assert property (supply_s |=> !led_enable_out
		&& error_flags_reg[bsl_pkg::FLAG_SUPPLY])
		else $error("outputs on during undervoltage");
endmodule

// >>> design/bsl_pkg.sv
// Register map, field positions, reset values and timing for the backlight register bank
package bsl_pkg;
	// Register offsets
	localparam logic [7:0] OFF_LEVEL = 8'h00;
	localparam logic [7:0] OFF_SETUP = 8'h01;
	localparam logic [7:0] OFF_FLAGS = 8'h02;
	// Reset values
	localparam logic [7:0] RST_LEVEL = 8'h00;
	localparam logic [7:0] RST_SETUP = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	// Device setup fields
	localparam int SETUP_EN_BIT   = 0;
	localparam int SETUP_MODE_LSB = 1;
	localparam int SETUP_MODE_MSB = 2;
	localparam logic [7:0] SETUP_USED_MASK = 8'h07;
	// Error flag positions
	localparam int FLAG_OPEN  = 7;
	localparam int FLAG_SHORT = 6;
	localparam int FLAG_MULTI = 5;
	localparam int FLAG_ONE   = 4;
	localparam int FLAG_ANY   = 3;
	localparam int FLAG_TRIP  = 2;
	localparam int FLAG_HEAT  = 1;
	localparam int FLAG_SUPPLY = 0;
	// Dimming source codes
	localparam logic [1:0] SRC_PIN_DUTY0 = 2'h0;
	localparam logic [1:0] SRC_PIN_DUTY1 = 2'h1;
	localparam logic [1:0] SRC_REGISTER  = 2'h2;
	localparam logic [1:0] SRC_PASS      = 2'h3;
	// Timing
	localparam int CLK_HZ       = 10000000;
	localparam int LOW_TIME_MS  = 50;
	localparam int TRIP_CYCLES  = LOW_TIME_MS * (CLK_HZ / 1000);
	localparam logic [7:0] PWM_WRAP = 8'hFF;
	// Synchroniser reset level
	localparam logic SYNC_RST = 1'b0;
endpackage

// >>> design/bsl_sync.sv
// Three-stage input synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
module bsl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk_in,
	input  wire logic         sys_rst_in,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s1_reg   <= {W{bsl_pkg::SYNC_RST}};
			s2_reg   <= {W{bsl_pkg::SYNC_RST}};
			s3_reg   <= {W{bsl_pkg::SYNC_RST}};
			sync_out <= {W{bsl_pkg::SYNC_RST}};
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					sync_out[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule

// >>> bench/bsl_host_model.sv
// Host-side register master model driving the parallel register port
`timescale 1ns/100ps
module bsl_host_model (
	// Clock
	input  wire logic       mclk_in,
	// Register port
	output logic      [7:0] reg_addr_out,
	output logic            reg_wr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_rd_out,
	input  wire logic [7:0] reg_rdata_in
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_out = 1'b0;
	end

	// One-cycle write strobe; data scrambled once released
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk_in);
		#1;
		reg_addr_out = addr;
		reg_wdata_out = data;
		reg_wr_out = 1'b1;
		@(posedge mclk_in);
		#1;
		reg_wr_out = 1'b0;
		reg_wdata_out = ~data;
	endtask

	// One-cycle read strobe; data taken the cycle after
	task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk_in);
		#1;
		reg_addr_out = addr;
		reg_rd_out = 1'b1;
		@(posedge mclk_in);
		#1;
		reg_rd_out = 1'b0;
		data = reg_rdata_in;
	endtask
endmodule

// >>> bench/bsl_regs_tb_top.sv
// Self-checking testbench for the backlight register bank
`timescale 1ns/100ps
module bsl_regs_tb_top;
	logic       mclk_in;
	logic       sys_rst_in;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       chip_en, dim_pin, fault_pin, fault_oe;
	logic [5:0] led_open, led_short;
	logic       boost_low, overheat, temp_ok, low_supply;
	logic       boost_en, led_en, pwm;
	logic [7:0] dim_duty;
	logic [7:0] pwm_high;
	int         num_errors = 0;
	int         check_count = 0;

	bsl_host_model i_host (.mclk_in(mclk_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
		.reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata));

	bsl_regs #(.CH(6), .TRIP_CYCLES(20)) i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .chip_en_in(chip_en),
		.dim_pin_in(dim_pin), .fault_pin_out(fault_pin), .fault_pin_oe_out(fault_oe),
		.led_open_in(led_open), .led_short_in(led_short), .boost_low_in(boost_low),
		.overheat_in(overheat), .temp_ok_in(temp_ok), .low_supply_in(low_supply),
		.boost_enable_out(boost_en), .led_enable_out(led_en), .pwm_out(pwm),
		.dim_duty_out(dim_duty));

	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] v;
		i_host.rd_reg(addr, v);
		chk(v, exp);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// High cycles of the dimming output over one full period
	task automatic count_pwm(output logic [7:0] n);
		n = 8'h00;
		repeat (256) begin
			@(posedge mclk_in);
			#1;
			n = n + {7'h00, pwm};
		end
	endtask

	task automatic end_test(input string name);
		$display("Test %s finished, errors so far %0d", name, num_errors);
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk_in);
		num_errors++;
		report_and_stop();
	end

	initial begin
		sys_rst_in = 1'b1;
		chip_en = 1'b1;
		dim_pin = 1'b0;
		led_open = 6'h00;
		led_short = 6'h00;
		boost_low = 1'b0;
		overheat = 1'b0;
		temp_ok = 1'b0;
		low_supply = 1'b0;
		wait_cyc(3);
		sys_rst_in = 1'b0;
		wait_cyc(6);
		// Reset values and unmapped read
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h02, 8'h00);
		rd_chk(8'h03, 8'h00);
		end_test("reset");
		// Setup field, unused bits, source codes
		i_host.wr_reg(8'h01, 8'hFF);
		rd_chk(8'h01, 8'h07);
		for (int m = 0; m < 4; m++) begin
			i_host.wr_reg(8'h01, {5'h00, m[1:0], 1'b1});
			rd_chk(8'h01, {5'h00, m[1:0], 1'b1});
		end
		wait_cyc(2);
		chk({7'h00, led_en}, 8'h01);
		i_host.wr_reg(8'h01, 8'h06);
		wait_cyc(3);
		chk({6'h00, led_en, boost_en}, 8'h00);
		end_test("setup");
		// Brightness register as source
		i_host.wr_reg(8'h00, 8'hA5);
		i_host.wr_reg(8'h01, 8'h05);
		rd_chk(8'h00, 8'hA5);
		wait_cyc(4);
		chk(dim_duty, 8'hA5);
		count_pwm(pwm_high);
		chk(pwm_high, 8'hA5);
		// Pin pass-through and measured pin duty
		dim_pin = 1'b1;
		i_host.wr_reg(8'h01, 8'h07);
		wait_cyc(8);
		chk({7'h00, pwm}, 8'h01);
		dim_pin = 1'b0;
		wait_cyc(8);
		chk({7'h00, pwm}, 8'h00);
		dim_pin = 1'b1;
		i_host.wr_reg(8'h01, 8'h01);
		wait_cyc(530);
		chk(dim_duty, 8'hFF);
		dim_pin = 1'b0;
		end_test("dimming");
		// Single open fault, read clears
		led_open = 6'h01;
		wait_cyc(5);
		led_open = 6'h00;
		wait_cyc(8);
		chk({7'h00, fault_oe}, 8'h01);
		chk({7'h00, fault_pin}, 8'h00);
		rd_chk(8'h02, 8'h98);
		rd_chk(8'h02, 8'h00);
		chk({7'h00, fault_oe}, 8'h00);
		// Two shorted channels
		led_short = 6'h12;
		wait_cyc(5);
		led_short = 6'h00;
		wait_cyc(8);
		i_host.wr_reg(8'h02, 8'h00);
		rd_chk(8'h02, 8'h68);
		end_test("led faults");
		// Enable pin low clears flags
		led_open = 6'h20;
		wait_cyc(5);
		led_open = 6'h00;
		wait_cyc(8);
		chip_en = 1'b0;
		wait_cyc(8);
		chk({7'h00, fault_oe}, 8'h00);
		chip_en = 1'b1;
		wait_cyc(8);
		rd_chk(8'h02, 8'h00);
		end_test("enable clear");
		// Boost low trip and restart
		boost_low = 1'b1;
		wait_cyc(40);
		chk({7'h00, boost_en}, 8'h00);
		boost_low = 1'b0;
		wait_cyc(8);
		rd_chk(8'h02, 8'h04);
		wait_cyc(4);
		chk({7'h00, boost_en}, 8'h01);
		end_test("boost trip");
		// Overheat holds outputs off until recovered
		overheat = 1'b1;
		wait_cyc(5);
		overheat = 1'b0;
		wait_cyc(12);
		chk({6'h00, led_en, boost_en}, 8'h00);
		rd_chk(8'h02, 8'h02);
		temp_ok = 1'b1;
		wait_cyc(8);
		chk({6'h00, led_en, boost_en}, 8'h03);
		end_test("overheat");
		// Undervoltage holds outputs off while present
		low_supply = 1'b1;
		wait_cyc(8);
		chk({7'h00, led_en}, 8'h00);
		low_supply = 1'b0;
		wait_cyc(8);
		chk({7'h00, led_en}, 8'h01);
		rd_chk(8'h02, 8'h01);
		end_test("undervoltage");
		report_and_stop();
	end
endmodule
